// ---- logic/wakeup_pkg.sv ----
/*
  Shared constants for the periodic wakeup counter: register offsets,
  field positions, reset values, source codes and the divide table.
  Assumes a Wishbone slave with byte addresses and 32-bit data.
*/
`default_nettype none
package wakeup_pkg;

  ////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_LIMIT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  ////////////////////////////////////////////////////////////////////
  // control register fields and the match bit of the status and mask registers
  localparam int FLAG_BIT = 7;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 5;
  localparam int IE_BIT = 4;
  localparam int PS_HI = 3;
  localparam int IRQ_MATCH_BIT = 0;

  ////////////////////////////////////////////////////////////////////
  // reset values and widths
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic MASK_RST = 1'h1;
  localparam int PRE_W = 18;
  localparam int SYNC_STAGES = 2;

  localparam logic [1:0] SRC_LPO = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

  // divide ratio of the prescaler; zero means switched off
  function automatic logic [PRE_W-1:0] divide_ratio(input logic hi_range,
                                                    input logic [3:0] ps);
    logic [PRE_W-1:0] r;
    r = 18'h0;
    case ({hi_range, ps})
      5'h01: r = 18'h00008;
      5'h02: r = 18'h00020;
      5'h03: r = 18'h00040;
      5'h04: r = 18'h00080;
      5'h05: r = 18'h00100;
      5'h06: r = 18'h00200;
      5'h07: r = 18'h00400;
      5'h08: r = 18'h00001;
      5'h09: r = 18'h00002;
      5'h0a: r = 18'h00004;
      5'h0b: r = 18'h0000a;
      5'h0c: r = 18'h00010;
      5'h0d: r = 18'h00064;
      5'h0e: r = 18'h001f4;
      5'h0f: r = 18'h003e8;
      5'h11: r = 18'h00400;
      5'h12: r = 18'h00800;
      5'h13: r = 18'h01000;
      5'h14: r = 18'h02000;
      5'h15: r = 18'h04000;
      5'h16: r = 18'h08000;
      5'h17: r = 18'h10000;
      5'h18: r = 18'h003e8;
      5'h19: r = 18'h007d0;
      5'h1a: r = 18'h01388;
      5'h1b: r = 18'h02710;
      5'h1c: r = 18'h04e20;
      5'h1d: r = 18'h0c350;
      5'h1e: r = 18'h186a0;
      5'h1f: r = 18'h30d40;
      default: r = 18'h0;
    endcase
    return r;
  endfunction : divide_ratio

endpackage : wakeup_pkg
`default_nettype wire

// ---- logic/clock_source_pick.sv ----
/*
  Picks one of three slow source clocks and turns its rising edges
  into one-cycle pulses. Source levels are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_source_pick
  import wakeup_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selection and source levels
  input wire logic [1:0] source_select,
  input wire logic low_power_osc,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic lpo_on,
  input wire logic ext_on,
  input wire logic int_on,
  input wire logic deep_stop_mode,
  // edge pulse
  output logic src_edge
);

  logic [2:0] prev_reg, prev_next;
  logic edge_reg, edge_next;
  logic [2:0] lvl;
  logic [2:0] usable;

  always_comb begin
    lvl = {internal_ref_clock, external_ref_clock, low_power_osc};
    // reference sources die in deep stop
    usable = {int_on & ~deep_stop_mode, ext_on & ~deep_stop_mode, lpo_on};
    prev_next = lvl;
    case (source_select)
      SRC_LPO: edge_next = lvl[0] & ~prev_reg[0] & usable[0];
      SRC_EXT: edge_next = lvl[1] & ~prev_reg[1] & usable[1];
      default: edge_next = lvl[2] & ~prev_reg[2] & usable[2];
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 3'h0;
      edge_reg <= 1'h0;
    end else begin
      prev_reg <= prev_next;
      edge_reg <= edge_next;
    end
  end

  assign src_edge = edge_reg;

  property p_deep_stop_src;
    @(posedge clk) disable iff (!rst_n)
      (deep_stop_mode && source_select != SRC_LPO) |=> !edge_reg;
  endproperty
  a_deep_stop_src: assert property (p_deep_stop_src)
    else $error("reference source ticked in deep stop");

  property p_all_off;
    @(posedge clk) disable iff (!rst_n)
      (!lpo_on && !ext_on && !int_on) |=> !edge_reg;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("edge seen with every source off");

endmodule : clock_source_pick
`default_nettype wire

// ---- logic/prescale_divider.sv ----
/*
  Prescaler: divides source edges by a ratio and emits one-cycle ticks.
  Assumes ratio is stable unless clear is raised alongside the change.
*/
`timescale 1ns/1ps
`default_nettype none
module prescale_divider
  import wakeup_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic src_edge,
  input wire logic [PRE_W-1:0] ratio,
  input wire logic clear,
  input wire logic freeze,
  // tick
  output logic tick
);

  logic [PRE_W-1:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'h0;
    if (clear) begin
      cnt_next = '0;
    end else if (freeze || ratio == '0 || !src_edge) begin
      cnt_next = cnt_reg;
    end else if (cnt_reg >= ratio - 18'h1) begin
      cnt_next = '0;
      tick_next = 1'h1;
    end else begin
      cnt_next = cnt_reg + 18'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  property p_freeze_no_tick;
    @(posedge clk) disable iff (!rst_n) freeze |=> !tick_reg;
  endproperty
  a_freeze_no_tick: assert property (p_freeze_no_tick)
    else $error("prescaler ticked while frozen");

  property p_off_no_tick;
    @(posedge clk) disable iff (!rst_n) (ratio == '0) |=> !tick_reg;
  endproperty
  a_off_no_tick: assert property (p_off_no_tick)
    else $error("prescaler ticked while off");

endmodule : prescale_divider
`default_nettype wire

// ---- logic/periodic_wakeup_counter.sv ----
/*
  Periodic wakeup counter: 8-bit up-counter with match limit, prescaled
  from one of three source clocks, Wishbone classic register slave and
  a level interrupt. Source clock inputs are levels synchronous to CLK.
*/
// Behaviour
// - one 8-bit up-counter compared against an 8-bit match limit.
// - three selectable sources: low-power oscillator, external and internal reference.
// - prescaler between source and counter with binary and decimal ratios.
// - match can raise an interrupt that software enables or disables.
// - counting continues in wait mode; enabled match interrupt ends wait.
// - counting continues in both stop modes; enabled match wakes processor.
// - oscillator works in both stop modes; references only in shallow stop.
// - with all sources off no counting and no wakeup.
// - debug mode freezes prescaler and counter.
// - after debug counting resumes unless limit or selections were changed.
// - no pins of its own; all ports are internal chip signals.
// - status-control register, read-only count register, match-limit register.
// - match sets the flag; writing one clears flag and request.
// - source select 00 oscillator, 01 external, 1x internal reference.
// - match returns count to zero; limit zero matches every tick.
// - changing prescaler or source selection clears prescaler and counter.
`timescale 1ns/1ps
`default_nettype none
module periodic_wakeup_counter
  import wakeup_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // source clocks and their enables
  input wire logic LOW_POWER_OSC,
  input wire logic EXTERNAL_REF_CLOCK,
  input wire logic INTERNAL_REF_CLOCK,
  input wire logic LPO_ON,
  input wire logic EXT_REF_ON,
  input wire logic INT_REF_ON,
  // processor modes
  input wire logic WAIT_MODE,
  input wire logic DEEP_STOP_MODE,
  input wire logic SHALLOW_STOP_MODE,
  input wire logic DEBUG_ACTIVE,
  // requests
  output logic IRQ,
  output logic WAKE_REQ
);

  ////////////////////////////////////////////////////////////////////
  // reset release
  logic [SYNC_STAGES-1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[SYNC_STAGES-2:0], 1'h1};
    end
  end

  assign rst_n = rst_sync_reg[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic flag_reg, flag_next;
  logic [1:0] src_reg, src_next;
  logic ie_reg, ie_next;
  logic [3:0] ps_reg, ps_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] limit_reg, limit_next;
  logic status_reg, status_next;
  logic mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;
  bus_state_t state_reg, state_next;
  logic [31:0] dat_reg, dat_next;

  logic req, wr, rd;
  logic wr_ctrl, wr_limit, wr_mask, rd_status;
  logic cfg_change, restart, match;
  logic src_edge, tick;
  logic [PRE_W-1:0] ratio;
  logic low_power;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  always_comb begin
    req = WB_CYC_I && WB_STB_I && state_reg == BUS_IDLE;
    wr = req && WB_WE_I && WB_SEL_I[0];
    rd = req && !WB_WE_I;
    wr_ctrl = wr && WB_ADR_I == OFS_CTRL;
    wr_limit = wr && WB_ADR_I == OFS_LIMIT;
    wr_mask = wr && WB_ADR_I == OFS_IRQ_MASK;
    // status clears on read
    rd_status = rd && WB_ADR_I == OFS_IRQ_STATUS;
  end

  ////////////////////////////////////////////////////////////////////
  // source pick and prescaler
  // three sources
  clock_source_pick i_clock_source_pick (
    .clk(CLK),
    .rst_n(rst_n),
    .source_select(src_reg),
    .low_power_osc(LOW_POWER_OSC),
    .external_ref_clock(EXTERNAL_REF_CLOCK),
    .internal_ref_clock(INTERNAL_REF_CLOCK),
    .lpo_on(LPO_ON),
    .ext_on(EXT_REF_ON),
    .int_on(INT_REF_ON),
    .deep_stop_mode(DEEP_STOP_MODE),
    .src_edge(src_edge)
  );

  assign ratio = divide_ratio(src_reg[0], ps_reg);

  prescale_divider i_prescale_divider (
    .clk(CLK),
    .rst_n(rst_n),
    .src_edge(src_edge),
    .ratio(ratio),
    .clear(restart),
    .freeze(DEBUG_ACTIVE),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // control, counter and flags
  always_comb begin
    src_next = src_reg;
    ie_next = ie_reg;
    ps_next = ps_reg;
    limit_next = limit_reg;
    mask_next = mask_reg;
    if (wr_ctrl) begin
      src_next = WB_DAT_I[SRC_HI:SRC_LO];
      ie_next = WB_DAT_I[IE_BIT];
      ps_next = WB_DAT_I[PS_HI:0];
    end
    if (wr_limit) begin
      limit_next = WB_DAT_I[7:0];
    end
    if (wr_mask) begin
      mask_next = WB_DAT_I[IRQ_MATCH_BIT];
    end
    cfg_change = wr_ctrl && (WB_DAT_I[SRC_HI:SRC_LO] != src_reg
                             || WB_DAT_I[PS_HI:0] != ps_reg);
    restart = cfg_change || wr_limit;
    match = tick && !restart && count_reg == limit_reg;
    count_next = count_reg;
    if (restart) begin
      count_next = COUNT_RST;
    end else if (match) begin
      count_next = 8'h0;
    end else if (tick) begin
      count_next = count_reg + 8'h1;
    end
    flag_next = flag_reg;
    if (match) begin
      flag_next = 1'h1;
    end else if (wr_ctrl && WB_DAT_I[FLAG_BIT]) begin
      flag_next = 1'h0;
    end
    status_next = status_reg;
    if (match) begin
      status_next = 1'h1;
    end else if (rd_status || (wr_ctrl && WB_DAT_I[FLAG_BIT])) begin
      status_next = 1'h0;
    end
    // enable and mask gate the request
    irq_next = status_reg && mask_reg && ie_reg;
    low_power = WAIT_MODE || DEEP_STOP_MODE || SHALLOW_STOP_MODE;
    wake_next = irq_next && low_power;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= CTRL_RST[FLAG_BIT];
      src_reg <= CTRL_RST[SRC_HI:SRC_LO];
      ie_reg <= CTRL_RST[IE_BIT];
      ps_reg <= CTRL_RST[PS_HI:0];
      count_reg <= COUNT_RST;
      limit_reg <= LIMIT_RST;
      status_reg <= 1'h0;
      mask_reg <= MASK_RST;
      irq_reg <= 1'h0;
      wake_reg <= 1'h0;
    end else begin
      flag_reg <= flag_next;
      src_reg <= src_next;
      ie_reg <= ie_next;
      ps_reg <= ps_next;
      count_reg <= count_next;
      limit_reg <= limit_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, unmapped reads give zero
  always_comb begin
    state_next = state_reg;
    dat_next = dat_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (req) begin
          state_next = BUS_ACK;
          dat_next = 32'h0;
          case (WB_ADR_I)
            OFS_CTRL: dat_next[7:0] = {flag_reg, src_reg, ie_reg, ps_reg};
            OFS_COUNT: dat_next[7:0] = count_reg;
            OFS_LIMIT: dat_next[7:0] = limit_reg;
            OFS_IRQ_STATUS: dat_next[IRQ_MATCH_BIT] = status_reg;
            OFS_IRQ_MASK: dat_next[IRQ_MATCH_BIT] = mask_reg;
            default: dat_next = 32'h0;
          endcase
        end
      end
      BUS_ACK: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BUS_IDLE;
      dat_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      dat_reg <= dat_next;
    end
  end

  assign WB_ACK_O = state_reg == BUS_ACK;
  assign WB_DAT_O = dat_reg;
  assign IRQ = irq_reg;
  assign WAKE_REQ = wake_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  property p_step;
    (tick && !restart && count_reg != limit_reg)
      |=> count_reg == $past(count_reg) + 8'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step on tick");

  property p_hold;
    (!tick && !restart) |=> count_reg == $past(count_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without tick");

  sequence s_match;
    tick && !restart && count_reg == limit_reg;
  endsequence

  sequence s_wrapped;
    count_reg == 8'h0 && flag_reg;
  endsequence

  property p_match_wrap;
    s_match |=> s_wrapped;
  endproperty
  a_match_wrap: assert property (p_match_wrap)
    else $error("match did not wrap and flag");

  property p_restart;
    restart |=> count_reg == 8'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("selection change did not clear count");

  property p_w1c;
    (wr_ctrl && WB_DAT_I[FLAG_BIT] && !match) |=> !flag_reg && !status_reg;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_w0_keeps;
    (wr_ctrl && !WB_DAT_I[FLAG_BIT] && flag_reg) |=> flag_reg;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps)
    else $error("write zero cleared flag");

  property p_irq_gate;
    !ie_reg |=> !irq_reg;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");

  property p_irq_rise;
    (status_reg && mask_reg && ie_reg) |=> irq_reg;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt missing");

  property p_wake;
    (irq_next && WAIT_MODE) |=> wake_reg;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wakeup from wait");

  property p_freeze;
    (DEBUG_ACTIVE && !restart) ##1 (DEBUG_ACTIVE && !restart)
      |=> count_reg == $past(count_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("counter moved in debug");

  property p_ack;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack held two cycles");

endmodule : periodic_wakeup_counter
`default_nettype wire

// ---- testbench/tb.sv ----
/*
  Self-checking bench for the periodic wakeup counter: register checks,
  counting, match flag, interrupt and wake requests, freeze and restarts.
  Assumes the Wishbone timing and reset release of the design's notes.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wakeup_pkg::*;

  logic clk, rstn, cyc, stb, we, ack, irq, wake;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rd;
  logic [2:0] src_lvl, src_on;
  logic wait_m, deep, shallow, debug;
  int bad_count = 0;
  int check_count = 0;

  periodic_wakeup_counter i_periodic_wakeup_counter (
    .CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .LOW_POWER_OSC(src_lvl[0]), .EXTERNAL_REF_CLOCK(src_lvl[1]),
    .INTERNAL_REF_CLOCK(src_lvl[2]), .LPO_ON(src_on[0]), .EXT_REF_ON(src_on[1]),
    .INT_REF_ON(src_on[2]), .WAIT_MODE(wait_m), .DEEP_STOP_MODE(deep),
    .SHALLOW_STOP_MODE(shallow), .DEBUG_ACTIVE(debug), .IRQ(irq), .WAKE_REQ(wake)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one classic cycle; polls for the answer, at most 20 cycles
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      $display("wrong value ack expected 1 seen timeout");
      final_report();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(name, {24'h0, e}, rd);
  endtask : rchk

  // settled level checks; both outputs are registered
  task automatic pins(input logic ei, input logic ew);
    repeat (3) @(posedge clk);
    check("irq", {31'h0, ei}, {31'h0, irq});
    check("wake", {31'h0, ew}, {31'h0, wake});
  endtask : pins

  // n rising edges of one source, then let the counter settle
  task automatic edges(input int s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      src_lvl[s] <= 1'b1;
      repeat (2) @(posedge clk);
      src_lvl[s] <= 1'b0;
      @(posedge clk);
    end
    repeat (5) @(posedge clk);
  endtask : edges

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] ofs [6];
    logic [7:0] rv [6];
    ofs = '{OFS_CTRL, OFS_COUNT, OFS_LIMIT, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h14};
    rv = '{CTRL_RST, COUNT_RST, LIMIT_RST, 8'h00, {7'h0, MASK_RST}, 8'h00};
    rstn = 1'b0;
    {cyc, stb, we, wait_m, deep, shallow, debug} = 7'h00;
    adr = 8'h00;
    sel = 4'hf;
    dat_w = 32'h0;
    src_lvl = 3'h0;
    src_on = 3'h7;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) rchk("reset value", ofs[i], rv[i]);
    pins(1'b0, 1'b0);
    wr(OFS_COUNT, 8'h55);
    rchk("count read only", OFS_COUNT, 8'h00);
    wr(OFS_LIMIT, 8'h02);
    rchk("limit", OFS_LIMIT, 8'h02);
    wr(OFS_CTRL, 8'h18);
    rchk("ctrl", OFS_CTRL, 8'h18);
    // limit 2 at ratio 1: 1, 2, then wrap with flag
    edges(0, 1);
    rchk("count", OFS_COUNT, 8'h01);
    edges(0, 1);
    rchk("count", OFS_COUNT, 8'h02);
    pins(1'b0, 1'b0);
    edges(0, 1);
    rchk("count wrap", OFS_COUNT, 8'h00);
    rchk("flag set", OFS_CTRL, 8'h98);
    pins(1'b1, 1'b0);
    wr(OFS_IRQ_MASK, 8'h00);
    pins(1'b0, 1'b0);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_CTRL, 8'h08);
    pins(1'b0, 1'b0);
    wr(OFS_CTRL, 8'h18);
    rchk("flag kept", OFS_CTRL, 8'h98);
    pins(1'b1, 1'b0);
    wr(OFS_CTRL, 8'h98);
    rchk("flag cleared", OFS_CTRL, 8'h18);
    pins(1'b0, 1'b0);
    rchk("status cleared", OFS_IRQ_STATUS, 8'h00);
    // status is cleared by its own read
    edges(0, 3);
    rchk("status", OFS_IRQ_STATUS, 8'h01);
    rchk("status read", OFS_IRQ_STATUS, 8'h00);
    pins(1'b0, 1'b0);
    wr(OFS_CTRL, 8'h98);
    edges(0, 1);
    debug <= 1'b1;
    edges(0, 2);
    rchk("frozen", OFS_COUNT, 8'h01);
    debug <= 1'b0;
    edges(0, 1);
    rchk("resumed", OFS_COUNT, 8'h02);
    wr(OFS_CTRL, 8'h18);
    rchk("same ctrl", OFS_COUNT, 8'h02);
    wr(OFS_CTRL, 8'h19);
    rchk("prescale change", OFS_COUNT, 8'h00);
    edges(0, 1);
    rchk("ratio 2 half", OFS_COUNT, 8'h00);
    edges(0, 1);
    rchk("ratio 2 full", OFS_COUNT, 8'h01);
    wr(OFS_LIMIT, 8'h02);
    rchk("limit write", OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h10);
    edges(0, 2);
    rchk("prescaler off", OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h18);
    src_on <= 3'h0;
    edges(0, 2);
    rchk("sources off", OFS_COUNT, 8'h00);
    src_on <= 3'h7;
    // internal reference, ratio 1; other sources ignored
    wr(OFS_CTRL, 8'h58);
    edges(0, 1);
    edges(1, 1);
    edges(2, 1);
    rchk("internal src", OFS_COUNT, 8'h01);
    // external reference in the high range: 1000 edges per step
    wr(OFS_CTRL, 8'h38);
    edges(1, 999);
    rchk("ext 999", OFS_COUNT, 8'h00);
    edges(1, 1);
    rchk("ext 1000", OFS_COUNT, 8'h01);
    wr(OFS_CTRL, 8'h58);
    deep <= 1'b1;
    edges(2, 1);
    rchk("deep stop ref", OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h18);
    edges(0, 3);
    rchk("deep stop osc", OFS_CTRL, 8'h98);
    pins(1'b1, 1'b1);
    deep <= 1'b0;
    pins(1'b1, 1'b0);
    wait_m <= 1'b1;
    pins(1'b1, 1'b1);
    wait_m <= 1'b0;
    shallow <= 1'b1;
    wr(OFS_CTRL, 8'hd8);
    edges(2, 1);
    rchk("shallow ref", OFS_COUNT, 8'h01);
    pins(1'b0, 1'b0);
    shallow <= 1'b0;
    wr(OFS_LIMIT, 8'h00);
    edges(2, 1);
    rchk("limit zero flag", OFS_CTRL, 8'hd8);
    rchk("limit zero count", OFS_COUNT, 8'h00);
    // software stops the counter before wait: no count, no wakeup
    wr(OFS_CTRL, 8'h80);
    wait_m <= 1'b1;
    edges(0, 3);
    rchk("stopped in wait", OFS_COUNT, 8'h00);
    pins(1'b0, 1'b0);
    wait_m <= 1'b0;
    final_report();
  end
endmodule : tb
`default_nettype wire
